// ---- common/ppi_params.svh ----
`ifndef PPI_PARAMS_SVH
`define PPI_PARAMS_SVH
`define PPI_CC_W        15
`define PPI_WORD_W      25
`define PPI_ADDR_W      15
`define PPI_SAVE_PE     15'h0010
`define PPI_SAVE_CT     15'h0012
`define PPI_SAVE_IO     15'h0014
`define PPI_ENT_PE      15'h0011
`define PPI_ENT_CT      15'h0013
`define PPI_ENT_IO      15'h0015
`define PPI_MAC_INSTR   4'h1
`define PPI_MAC_OPND    4'h2
`define PPI_BIT_MOD3I   5
`define PPI_BIT_MOD3O   6
`define PPI_BIT_ADDER   7
`define PPI_SCAN_NS     4000
`define PPI_CLK_NS      40
`define PPI_SCAN_CYC    (`PPI_SCAN_NS / `PPI_CLK_NS)
`define PPI_OFF_CTRL    32'h0000_0000
`define PPI_OFF_STAT    32'h0000_0004
`define PPI_OFF_PEIND   32'h0000_0008
`define PPI_OFF_CTIND   32'h0000_000c
`define PPI_OFF_IOIND   32'h0000_0010
`endif

// ---- common/ppi_pkg.sv ----
package ppi_pkg;
	typedef enum logic [1:0] {
		PPI_NONE,
		PPI_PE,
		PPI_CT,
		PPI_IO
	} ppi_class_t;
	typedef enum logic [1:0] {
		PPI_RUN,
		PPI_SAVE,
		PPI_HALT
	} ppi_state_t;
endpackage

// ---- rtl/ppi_top.sv ----
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "ppi_params.svh"
// Behaviour
// - Priority: processor error, contingency, input-output.
// - Mode flag blocks own and lower classes.
// - Mode flags never block indicator setting, except error mode holding the channel io indicator.
// - Probe classes top-down at ending pulse.
// - Some error indicators probed every 4 us.
// - Taking interrupt sets that class mode flag.
// - Save word: counter bits 1-15, zero above.
// - Save/entry locations 16/17, 18/19, 20/21.
// - Class reset clears indicators and mode flag.
// - After reset, block contingency and io until next completes.
// - After return jump, recheck served and lower.
// - Higher class always able to interrupt.
// - Error probed always; ignores lower mode flags.
// - Second error under error mode halts.
// - Lower classes deferred past error reset.
// - Address check coded in bits 1-4.
// - Channel address error sets io indicator later.
// - Instruction residue failure sets bit 5.
// - Operand residue failure sets bit 6, ends.
// - Predicted versus actual residue sets bit 7.
// - Error test/reset use instruction bits 1-7.
module ppi_top (
	input  wire logic                    clk_sys,
	input  wire logic                    arst_n,
	input  wire logic                    clk_en,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [31:0]             paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    end_pulse,
	input  wire logic                    return_jump,
	input  wire logic                    is_xfer_instr,
	input  wire logic [`PPI_CC_W-1:0]    ctrl_counter,
	input  wire logic                    addr_err,
	input  wire logic [3:0]              addr_err_src,
	input  wire logic                    mod3_instr_err,
	input  wire logic                    mod3_opnd_err,
	input  wire logic                    adder_checked,
	input  wire logic [1:0]              opnd_check,
	input  wire logic [1:0]              oper_check,
	input  wire logic [1:0]              result_check,
	input  wire logic                    add_sub,
	input  wire logic [5:0]              ct_set,
	input  wire logic [7:0]              io_set,
	input  wire logic                    inhibit_io,
	input  wire logic                    test_proc_error_instr,
	input  wire logic                    reset_proc_error_instr,
	input  wire logic                    reset_contingency_instr,
	input  wire logic                    reset_io_indicator_instr,
	input  wire logic [9:0]              instr_sel,
	output logic                         test_result,
	output logic                         mem_wr,
	output logic      [`PPI_ADDR_W-1:0]  mem_addr,
	output logic      [`PPI_WORD_W-1:0]  mem_wdata,
	output logic                         jump_valid,
	output logic      [`PPI_ADDR_W-1:0]  jump_addr,
	output logic                         force_end,
	output logic                         cpu_halt,
	output logic                         proc_error_mode_flag,
	output logic                         contingency_mode_flag,
	output logic                         io_mode_flag
);
	logic                    rst_m;
	logic                    rst_n;
	logic [6:0]              pe_ind;
	logic [5:0]              ct_ind;
	logic [7:0]              io_ind;
	logic [3:0]              pe_chan;
	logic                    pend_io_chan;
	logic                    block_all;
	logic                    defer_low;
	logic [6:0]              scan_cnt;
	logic                    scan_tick;
	logic                    scan_en;
	ppi_pkg::ppi_state_t     state;
	ppi_pkg::ppi_class_t     take;
	logic                    any_pe;
	logic [6:0]              pe_new;
	logic                    probe;
	logic [1:0]              pred;
	logic                    low_ok;

	// Mod-3 add of residues; subtract uses complement residue
	function automatic logic [1:0] ppi_mod3(input logic [1:0] a, input logic [1:0] b);
		logic [2:0] s;
		s = {1'b0, a} + {1'b0, b};
		if (s >= 3'd3)
			ppi_mod3 = 2'(s - 3'd3);
		else
			ppi_mod3 = s[1:0];
		if (ppi_mod3 == 2'd3)
			ppi_mod3 = 2'd0;
	endfunction

	function automatic logic [1:0] ppi_neg3(input logic [1:0] a);
		ppi_neg3 = (a == 2'd1) ? 2'd2 : ((a == 2'd2) ? 2'd1 : 2'd0);
	endfunction

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rst_m <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_m <= 1'b1;
			rst_n <= rst_m;
		end
	end

	// Adder residue prediction
	always_comb begin
		pred = add_sub ? ppi_mod3(opnd_check, ppi_neg3(oper_check))
			: ppi_mod3(opnd_check, oper_check);
	end

	// New error indicator events; bit 0 is the address-check summary
	always_comb begin
		pe_new = 7'h00;
		pe_new[0] = addr_err;
		pe_new[`PPI_BIT_MOD3I-1] = mod3_instr_err;
		pe_new[`PPI_BIT_MOD3O-1] = mod3_opnd_err && !is_xfer_instr;
		pe_new[`PPI_BIT_ADDER-1] = adder_checked && (pred != result_check);
	end

	assign any_pe = |pe_ind;
	assign scan_tick = (scan_cnt == 7'(`PPI_SCAN_CYC - 1));
	assign probe = end_pulse || return_jump;
	// Shared gate of the two lower classes: the error or contingency mode flag, or a window, holds them
	assign low_ok = probe && !block_all && !defer_low && !proc_error_mode_flag
		&& !contingency_mode_flag;

	// Class selection, highest first
	always_comb begin
		take = ppi_pkg::PPI_NONE;
		if (state == ppi_pkg::PPI_RUN) begin
			if (any_pe && !proc_error_mode_flag && (probe || (scan_tick && scan_en)))
				take = ppi_pkg::PPI_PE;
			else if (low_ok && |ct_ind)
				take = ppi_pkg::PPI_CT;
			else if (low_ok && !io_mode_flag && !inhibit_io && |io_ind)
				take = ppi_pkg::PPI_IO;
		end
	end

	// Periodic error probe tick, free running
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			scan_cnt <= 7'h00;
		else if (clk_en)
			scan_cnt <= scan_tick ? 7'h00 : 7'(scan_cnt + 7'h01);
	end

	// Keeps the tick quiet in the first cycle after reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			scan_en <= 1'b0;
		else if (clk_en)
			scan_en <= 1'b1;
	end

	// Error indicators; set wins over reset in the same cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pe_ind <= 7'h00;
			pe_chan <= 4'h0;
		end else if (clk_en) begin
			if (reset_proc_error_instr)
				pe_ind <= (pe_ind & ~instr_sel[6:0]) | pe_new;
			else
				pe_ind <= pe_ind | pe_new;
			if (addr_err)
				pe_chan <= addr_err_src;
		end
	end

	// Channel address error is carried to the io class once error mode clears
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pend_io_chan <= 1'b0;
		end else if (clk_en) begin
			if (addr_err && addr_err_src > `PPI_MAC_OPND)
				pend_io_chan <= 1'b1;
			else if (!proc_error_mode_flag)
				pend_io_chan <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ct_ind <= 6'h00;
			io_ind <= 8'h00;
		end else if (clk_en) begin
			ct_ind <= (reset_contingency_instr ? (ct_ind & ~instr_sel[5:0]) : ct_ind)
				| ct_set;
			io_ind <= (reset_io_indicator_instr ? (io_ind & ~instr_sel[7:0]) : io_ind)
				| io_set
				| {7'h00, pend_io_chan && !proc_error_mode_flag
					&& !(addr_err && addr_err_src > `PPI_MAC_OPND)};
		end
	end

	// Mode flags; taking an interrupt beats a reset instruction in the same cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			proc_error_mode_flag <= 1'b0;
		else if (clk_en && take == ppi_pkg::PPI_PE)
			proc_error_mode_flag <= 1'b1;
		else if (clk_en && reset_proc_error_instr)
			proc_error_mode_flag <= 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			contingency_mode_flag <= 1'b0;
		else if (clk_en && take == ppi_pkg::PPI_CT)
			contingency_mode_flag <= 1'b1;
		else if (clk_en && reset_contingency_instr)
			contingency_mode_flag <= 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			io_mode_flag <= 1'b0;
		else if (clk_en && take == ppi_pkg::PPI_IO)
			io_mode_flag <= 1'b1;
		else if (clk_en && reset_io_indicator_instr)
			io_mode_flag <= 1'b0;
	end

	// Quiet window after a class reset lasts to the next completion
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			block_all <= 1'b0;
			defer_low <= 1'b0;
		end else if (clk_en) begin
			if (end_pulse && (reset_proc_error_instr || reset_contingency_instr
				|| reset_io_indicator_instr))
				block_all <= 1'b1;
			else if (end_pulse)
				block_all <= 1'b0;
			if (end_pulse && reset_proc_error_instr)
				defer_low <= 1'b1;
			else if (end_pulse)
				defer_low <= 1'b0;
		end
	end

	// Save and vector sequencing; halt on a further error in error mode
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= ppi_pkg::PPI_RUN;
			mem_wr <= 1'b0;
			mem_addr <= '0;
			mem_wdata <= '0;
			jump_valid <= 1'b0;
			jump_addr <= '0;
		end else if (clk_en) begin
			mem_wr <= 1'b0;
			jump_valid <= 1'b0;
			unique case (state)
				ppi_pkg::PPI_RUN: begin
					if (proc_error_mode_flag && |pe_new) begin
						state <= ppi_pkg::PPI_HALT;
					end else if (take != ppi_pkg::PPI_NONE) begin
						state <= ppi_pkg::PPI_SAVE;
						mem_wr <= 1'b1;
						mem_wdata <= {10'h000, ctrl_counter};
						unique case (take)
							ppi_pkg::PPI_PE: begin
								mem_addr <= `PPI_SAVE_PE;
								jump_addr <= `PPI_ENT_PE;
							end
							ppi_pkg::PPI_CT: begin
								mem_addr <= `PPI_SAVE_CT;
								jump_addr <= `PPI_ENT_CT;
							end
							default: begin
								mem_addr <= `PPI_SAVE_IO;
								jump_addr <= `PPI_ENT_IO;
							end
						endcase
					end
				end
				ppi_pkg::PPI_SAVE: begin
					jump_valid <= 1'b1;
					state <= ppi_pkg::PPI_RUN;
				end
				ppi_pkg::PPI_HALT: begin
					state <= ppi_pkg::PPI_HALT;
				end
			endcase
		end
	end

	// Halt is sticky until the next system reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			cpu_halt <= 1'b0;
		else if (clk_en && state == ppi_pkg::PPI_RUN && proc_error_mode_flag && |pe_new)
			cpu_halt <= 1'b1;
	end

	// Operand residue failure ends the instruction early
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			force_end <= 1'b0;
		else if (clk_en)
			force_end <= pe_new[`PPI_BIT_MOD3O-1];
	end

	// Indicator test answer
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			test_result <= 1'b0;
		else if (clk_en && test_proc_error_instr)
			test_result <= ((instr_sel[3:0] == pe_chan) && pe_ind[0])
				|| |(instr_sel[6:4] & pe_ind[6:4]);
	end

	// APB slave, zero wait states: ready stands through the access cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			pready <= 1'b0;
		else if (clk_en)
			pready <= psel && !penable;
	end

	// Mode flags are read-only here
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pslverr <= 1'b0;
			if (psel && !penable) begin
				pslverr <= pwrite;
				unique case (paddr)
					`PPI_OFF_CTRL: prdata <= {31'h0, scan_en};
					`PPI_OFF_STAT: prdata <= {27'h0, cpu_halt, block_all, io_mode_flag,
						contingency_mode_flag, proc_error_mode_flag};
					`PPI_OFF_PEIND: prdata <= {21'h0, pe_chan, pe_ind};
					`PPI_OFF_CTIND: prdata <= {26'h0, ct_ind};
					`PPI_OFF_IOIND: prdata <= {24'h0, io_ind};
					default: begin
						prdata <= 32'h0000_0000;
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end
endmodule

// ---- tb/ppi_top_properties.sv ----
`timescale 1ns/1ps
`include "ppi_params.svh"
module ppi_checker (
	input wire logic                   clk_sys,
	input wire logic                   arst_n,
	input wire logic                   mem_wr,
	input wire logic [`PPI_ADDR_W-1:0] mem_addr,
	input wire logic [`PPI_WORD_W-1:0] mem_wdata,
	input wire logic                   jump_valid,
	input wire logic [`PPI_ADDR_W-1:0] jump_addr,
	input wire logic                   cpu_halt,
	input wire logic                   proc_error_mode_flag,
	input wire logic                   contingency_mode_flag
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	sequence s_save;
		mem_wr ##1 jump_valid;
	endsequence
	sequence s_save_pe;
		mem_wr && mem_addr == `PPI_SAVE_PE;
	endsequence
	property p_save_then_jump;
		mem_wr |=> jump_valid;
	endproperty
	property p_jump_target;
		s_save |-> jump_addr == $past(mem_addr) + 15'h0001;
	endproperty
	property p_save_word;
		mem_wr |-> mem_wdata[24:15] == 10'h000;
	endproperty
	property p_save_loc;
		mem_wr |-> mem_addr inside {`PPI_SAVE_PE, `PPI_SAVE_CT, `PPI_SAVE_IO};
	endproperty
	property p_pe_flag;
		s_save_pe |-> ##[0:1] proc_error_mode_flag;
	endproperty
	property p_pe_blocks;
		proc_error_mode_flag && mem_wr |-> mem_addr == `PPI_SAVE_PE;
	endproperty
	property p_ct_blocks;
		contingency_mode_flag && mem_wr |-> mem_addr != `PPI_SAVE_IO;
	endproperty
	property p_halt_stays;
		$rose(cpu_halt) |-> (cpu_halt && !mem_wr) [*8];
	endproperty
	property p_save_pulse;
		mem_wr |=> !mem_wr;
	endproperty
	a_save_then_jump: assert property (p_save_then_jump) else $error("no jump after save");
	a_jump_target: assert property (p_jump_target) else $error("jump not save plus one");
	a_save_word: assert property (p_save_word) else $error("save word upper bits set");
	a_save_loc: assert property (p_save_loc) else $error("save to unknown location");
	a_pe_flag: assert property (p_pe_flag) else $error("error mode flag not set");
	a_pe_blocks: assert property (p_pe_blocks) else $error("lower class under error mode");
	a_ct_blocks: assert property (p_ct_blocks) else $error("io taken under contingency");
	a_halt_stays: assert property (p_halt_stays) else $error("halt released or saved");
	a_save_pulse: assert property (p_save_pulse) else $error("save longer than a cycle");
endmodule
bind ppi_top ppi_checker i_chk (.clk_sys, .arst_n, .mem_wr, .mem_addr, .mem_wdata, .jump_valid,
	.jump_addr, .cpu_halt, .proc_error_mode_flag, .contingency_mode_flag);

// ---- tb/ppi_seq_model.sv ----
`timescale 1ns/1ps
`include "ppi_params.svh"
module ppi_seq_model #(
	parameter int INSTR_CYC = 4
) (
	input  wire logic                   clk_sys,
	input  wire logic                   arst_n,
	input  wire logic                   run,
	input  wire logic                   cpu_halt,
	input  wire logic                   jump_valid,
	input  wire logic [`PPI_ADDR_W-1:0] jump_addr,
	output logic                        end_pulse,
	output logic      [`PPI_CC_W-1:0]   ctrl_counter
);
	logic [3:0] phase;
	// Counter moves only after the ending pulse so the save sees a stable value
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			phase <= 4'h0;
			end_pulse <= 1'b0;
			ctrl_counter <= 15'h0100;
		end else begin
			end_pulse <= 1'b0;
			if (jump_valid) begin
				ctrl_counter <= jump_addr;
				phase <= 4'h0;
			end else if (run && !cpu_halt) begin
				if (phase == 4'(INSTR_CYC - 1)) begin
					phase <= 4'h0;
					end_pulse <= 1'b1;
				end else begin
					phase <= phase + 4'h1;
				end
				if (end_pulse) begin
					ctrl_counter <= ctrl_counter + 15'h0001;
				end
			end
		end
	end
endmodule

// ---- tb/tb_priority_program_interrupt.sv ----
`timescale 1ns/1ps
`include "ppi_params.svh"
module tb_priority_program_interrupt;
	logic        clk_sys = 1'b0, arst_n = 1'b0, run = 1'b0, err;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
	logic        addr_err = 1'b0, mod3_instr_err = 1'b0, mod3_opnd_err = 1'b0;
	logic        adder_checked = 1'b0, add_sub = 1'b0, reset_proc_error_instr = 1'b0;
	logic        reset_contingency_instr = 1'b0, reset_io_indicator_instr = 1'b0;
	logic [1:0]  opnd_check = 2'h0, oper_check = 2'h0, result_check = 2'h0;
	logic [3:0]  addr_err_src = 4'h0;
	logic [5:0]  ct_set = 6'h0;
	logic [7:0]  io_set = 8'h0;
	logic [9:0]  instr_sel = 10'h0;
	logic        end_pulse, mem_wr, jump_valid, cpu_halt, io_mode_flag;
	logic        proc_error_mode_flag, contingency_mode_flag;
	logic [14:0] ctrl_counter, mem_addr, jump_addr, prev_cc;
	logic [24:0] mem_wdata;
	int          bad_count = 0, checks = 0, wr_count = 0, n0;
	ppi_top i_dut (.clk_sys, .arst_n, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .end_pulse, .return_jump(1'b0), .is_xfer_instr(1'b0),
		.ctrl_counter, .addr_err, .addr_err_src, .mod3_instr_err, .mod3_opnd_err, .adder_checked,
		.opnd_check, .oper_check, .result_check, .add_sub, .ct_set, .io_set, .inhibit_io(1'b0),
		.test_proc_error_instr(1'b0), .reset_proc_error_instr, .reset_contingency_instr,
		.reset_io_indicator_instr, .instr_sel, .test_result(), .mem_wr, .mem_addr, .mem_wdata,
		.jump_valid, .jump_addr, .force_end(), .cpu_halt, .proc_error_mode_flag,
		.contingency_mode_flag, .io_mode_flag);
	ppi_seq_model i_seq (.clk_sys, .arst_n, .run, .cpu_halt, .jump_valid, .jump_addr,
		.end_pulse, .ctrl_counter);
	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		prev_cc <= ctrl_counter;
		if (mem_wr === 1'b1) wr_count++;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [31:0] a);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(negedge clk_sys);
		while (pready !== 1'b1 && n < 50) begin @(negedge clk_sys); n++; end
		rd = prdata;
		err = pslverr;
		@(posedge clk_sys);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic take(input logic [14:0] sa);
		int n;
		n = 0;
		do begin @(negedge clk_sys); n++; end while (mem_wr !== 1'b1 && n < 300);
		chk("save_addr", mem_addr, sa);
		chk("save_word", mem_wdata, {10'h000, prev_cc});
		@(negedge clk_sys);
		chk("jump_valid", jump_valid, 1'b1);
		chk("jump_addr", jump_addr, sa + 15'h0001);
		@(posedge clk_sys);
	endtask
	// Returns on the edge that samples the ending pulse
	task automatic end_instr;
		int n;
		n = 0;
		do begin @(negedge clk_sys); n++; end while (end_pulse !== 1'b1 && n < 50);
		@(posedge clk_sys);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		#2000000;
		bad_count++;
		tally_and_finish;
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		for (int a = 0; a <= 16; a += 4) begin
			apb(1'b0, 32'(a));
			chk("reset_value", rd, (a == 0) ? 32'h1 : 32'h0);
			chk("read_ok", err, 1'b0);
		end
		apb(1'b0, 32'h0000_0040);
		chk("unmapped", err, 1'b1);
		apb(1'b1, `PPI_OFF_CTRL);
		chk("ro_write", err, 1'b1);
		$display("test 1 done");
		run <= 1'b1;
		io_set <= 8'h01;
		@(posedge clk_sys);
		io_set <= 8'h00;
		take(`PPI_SAVE_IO);
		chk("io_flag", io_mode_flag, 1'b1);
		ct_set <= 6'h01;
		@(posedge clk_sys);
		ct_set <= 6'h00;
		take(`PPI_SAVE_CT);
		chk("ct_flag", contingency_mode_flag, 1'b1);
		mod3_instr_err <= 1'b1;
		@(posedge clk_sys);
		mod3_instr_err <= 1'b0;
		take(`PPI_SAVE_PE);
		chk("pe_flag", proc_error_mode_flag, 1'b1);
		$display("test 2 done");
		io_set <= 8'h02;
		ct_set <= 6'h02;
		@(posedge clk_sys);
		io_set <= 8'h00;
		ct_set <= 6'h00;
		n0 = wr_count;
		repeat (40) @(posedge clk_sys);
		chk("deferred", wr_count - n0, 32'h0);
		apb(1'b0, `PPI_OFF_CTIND);
		chk("ct_ind_set", rd, 32'h3);
		end_instr;
		// Position 5 selects the instruction residue indicator
		reset_proc_error_instr <= 1'b1;
		instr_sel <= 10'h010;
		end_instr;
		reset_proc_error_instr <= 1'b0;
		instr_sel <= 10'h000;
		@(negedge clk_sys);
		chk("pe_flag_clear", proc_error_mode_flag, 1'b0);
		$display("test 3 done");
		@(posedge clk_sys);
		mod3_instr_err <= 1'b1;
		@(posedge clk_sys);
		mod3_instr_err <= 1'b0;
		take(`PPI_SAVE_PE);
		// Mismatch holds for add and subtract alike
		opnd_check <= 2'h1;
		result_check <= 2'h2;
		add_sub <= 1'b1;
		adder_checked <= 1'b1;
		@(posedge clk_sys);
		adder_checked <= 1'b0;
		n0 = 0;
		do begin @(negedge clk_sys); n0++; end while (cpu_halt !== 1'b1 && n0 < 300);
		chk("halt", cpu_halt, 1'b1);
		$display("test 4 done");
		tally_and_finish;
	end
endmodule
